// ---- verilog/i2cc_defs.vh ----
// register map, field positions, reset values and sequence constants
`ifndef I2CC_DEFS_VH
`define I2CC_DEFS_VH

// register byte offsets
`define I2CC_CMD 8'h00
`define I2CC_CTRL_STAT 8'h04
`define I2CC_TGT_STAT 8'h08
`define I2CC_FILT_HIT 8'h0C
`define I2CC_FILT_DIR 8'h10
`define I2CC_IRQ_FLAG 8'h20
`define I2CC_IRQ_CLR 8'h24
`define I2CC_IRQ_EN 8'h28
`define I2CC_SAMPLE_DIV 8'h30
`define I2CC_TIMEOUT 8'h34
`define I2CC_SETUP 8'h38
`define I2CC_LOW 8'h3C
`define I2CC_HIGH 8'h40
`define I2CC_FREE 8'h44
`define I2CC_OVERRIDE 8'h48
`define I2CC_TADDR0 8'h88
`define I2CC_TADDR1 8'h8C

// interrupt flag positions
`define I2CC_IRQ_START 4
`define I2CC_IRQ_RESTART 5
`define I2CC_IRQ_END 6
`define I2CC_IRQ_DROP 7
`define I2CC_IRQ_GEN_EXIT 15
`define I2CC_IRQ_GEN_ENTER 16
`define I2CC_IRQ_FILTER 17
`define I2CC_IRQ_MASK 32'h0003_80F0

// controller status and command positions
`define I2CC_CS_BUSY 0
`define I2CC_CS_START 4
`define I2CC_CS_STOP 5
`define I2CC_CS_DROP 6
`define I2CC_CS_RECOVER 7
`define I2CC_CS_ERR_START 9
`define I2CC_CS_ERR_STOP 10
`define I2CC_CS_ERR_REC 11

// target status positions
`define I2CC_TS_FRAME 0
`define I2CC_TS_SDA 1
`define I2CC_TS_SCL 2

// override fields and target address fields
`define I2CC_OVR_SDA 1
`define I2CC_OVR_SCL 2
`define I2CC_TA_EN 31
`define I2CC_TA_HI 6

// reset values
`define I2CC_TIME_RST 32'h0000_0004
`define I2CC_OVR_RST 32'h0000_0006
`define I2CC_ZERO 32'h0000_0000

// recover pulses and address bit count
`define I2CC_REC_PULSES 4'h9
`define I2CC_LAST_BIT 3'h7

`endif

// ---- verilog/i2cc_line_sampler.v ----
// sda/scl synchroniser and divided line sampler
`timescale 1ns/1ps
`include "i2cc_defs.vh"

module i2cc_line_sampler #(
  parameter CNT_W = 32
) (
  input wire pclk,
  input wire presetn,
  input wire sda_pin,
  input wire scl_pin,
  input wire [CNT_W-1:0] line_sample_divider,
  output reg sda_s,
  output reg scl_s
);

  reg [1:0] sda_sync; // two-stage synchroniser
  reg [1:0] scl_sync;
  reg [CNT_W-1:0] div_cnt; // cycles since last sample

  // plain two-flop synchronisers, first stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync <= 2'h3;
      scl_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], sda_pin};
      scl_sync <= {scl_sync[0], scl_pin};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= {CNT_W{1'b0}};
      sda_s <= 1'b1; // idle bus reads high
      scl_s <= 1'b1;
    end else if (div_cnt >= line_sample_divider) begin
      div_cnt <= {CNT_W{1'b0}};
      sda_s <= sda_sync[1];
      scl_s <= scl_sync[1];
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

endmodule // i2cc_line_sampler

// ---- verilog/i2cc_top.v ----
// i2c controller/target status, timing and address filter with apb registers
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "i2cc_defs.vh"

module i2cc_top #(
  parameter CNT_W = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  output wire irq
);

  // controller states
  localparam ST_IDLE = 4'h0;
  localparam ST_WFREE = 4'h1; // waiting for bus-free time
  localparam ST_SSDA = 4'h2; // sda low, scl high
  localparam ST_SSCL = 4'h3; // scl pulled low
  localparam ST_HOLD = 4'h4; // own the bus, scl low
  localparam ST_PSETUP = 4'h5; // stop: sda low set up under scl low
  localparam ST_PSCL = 4'h6; // stop: scl released
  localparam ST_PSDA = 4'h7; // stop: sda released
  localparam ST_RLOW = 4'h8; // recover clock low
  localparam ST_RHIGH = 4'h9; // recover clock high

  // configuration registers
  reg [31:0] line_sample_divider;
  reg [31:0] timeout_count;
  reg [31:0] data_setup_count;
  reg [31:0] scl_low_count;
  reg [31:0] scl_high_count;
  reg [31:0] bus_free_count;
  reg [31:0] override;
  reg [31:0] target_address_setting_0;
  reg [31:0] target_address_setting_1;
  reg [31:0] irq_enable;
  reg [31:0] irq_flags; // sticky event flags

  // controller state
  reg [3:0] state;
  reg [31:0] phase_cnt; // cycles spent in the current phase
  reg [3:0] rec_cnt; // recover pulses done
  reg [31:0] free_cnt; // cycles since last stop or drop
  reg req_start;
  reg req_stop;
  reg req_drop;
  reg req_rec;
  reg err_start;
  reg err_stop;
  reg err_rec;
  reg drv_sda; // controller pulls sda low
  reg drv_scl; // controller pulls scl low

  // target side state
  reg in_frame;
  reg addr_phase; // collecting the address byte
  reg [2:0] bit_cnt;
  reg [7:0] addr_shift;
  reg [1:0] filter_hit;
  reg filter_dir;
  reg [31:0] idle_cnt; // inactive cycles within a frame

  // sampled lines and their previous values
  wire sda_s;
  wire scl_s;
  reg sda_p;
  reg scl_p;

  // bus decode
  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  reg addr_ok;
  reg [31:0] next_prdata;
  reg [31:0] set_vec; // flag events seen this cycle
  reg [31:0] clr_vec; // flags written one to clear

  i2cc_line_sampler #(
    .CNT_W(32)
  ) u_sampler (
    .pclk(pclk),
    .presetn(presetn),
    .sda_pin(sda_i),
    .scl_pin(scl_i),
    .line_sample_divider(line_sample_divider),
    .sda_s(sda_s),
    .scl_s(scl_s)
  );

  // bus condition detection on sampled levels
  wire start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
  wire scl_rise = scl_s & ~scl_p;
  wire activity = (sda_s ^ sda_p) | (scl_s ^ scl_p);

  // frame dropped after timeout+1 silent cycles
  wire timeout_hit = in_frame & ~activity & (idle_cnt >= timeout_count);

  // controller drop: software request or timeout while sequencing
  wire ctrl_drop = (req_drop | timeout_hit) & (state != ST_IDLE);
  wire drop_evt = timeout_hit | ctrl_drop;

  // phase end tests, count runs 0..n so each phase is n+1 cycles
  wire low_done = phase_cnt >= scl_low_count;
  wire high_done = phase_cnt >= scl_high_count;
  wire setup_done = phase_cnt >= data_setup_count;
  wire bus_free = (free_cnt >= bus_free_count) & sda_s & scl_s & ~in_frame;

  // address byte completion and filter compare
  wire [7:0] addr_byte = {addr_shift[6:0], sda_s};
  wire addr_done = addr_phase & scl_rise & (bit_cnt == `I2CC_LAST_BIT);
  wire hit0 = target_address_setting_0[`I2CC_TA_EN] &
    (addr_byte[7:1] == target_address_setting_0[`I2CC_TA_HI:0]);
  wire hit1 = target_address_setting_1[`I2CC_TA_EN] &
    (addr_byte[7:1] == target_address_setting_1[`I2CC_TA_HI:0]);

  // clock generation enter and exit events
  wire gen_enter = (state == ST_SSDA) & high_done & scl_s;
  wire gen_exit = (state != ST_IDLE) & ((state == ST_PSDA) | ctrl_drop);

  // lines only ever pulled low, output data fixed low
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  // override zero pulls the line low
  assign sda_oe = drv_sda | ~override[`I2CC_OVR_SDA];
  assign scl_oe = drv_scl | ~override[`I2CC_OVR_SCL];

  // zero-wait slave, error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // level interrupt from enabled sticky flags
  assign irq = |(irq_flags & irq_enable);

  // previous sampled levels for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_p <= 1'b1;
      scl_p <= 1'b1;
    end else begin
      sda_p <= sda_s;
      scl_p <= scl_s;
    end
  end

  // read mux, also flags unmapped offsets
  always @* begin
    addr_ok = 1'b1;
    next_prdata = `I2CC_ZERO;
    case (paddr)
      `I2CC_CMD: next_prdata = `I2CC_ZERO;
      `I2CC_CTRL_STAT: begin
        next_prdata[`I2CC_CS_BUSY] = state != ST_IDLE;
        next_prdata[`I2CC_CS_START] = req_start;
        next_prdata[`I2CC_CS_STOP] = req_stop;
        next_prdata[`I2CC_CS_DROP] = req_drop;
        next_prdata[`I2CC_CS_RECOVER] = req_rec;
        next_prdata[`I2CC_CS_ERR_START] = err_start;
        next_prdata[`I2CC_CS_ERR_STOP] = err_stop;
        next_prdata[`I2CC_CS_ERR_REC] = err_rec;
      end
      `I2CC_TGT_STAT: begin
        next_prdata[`I2CC_TS_FRAME] = in_frame;
        next_prdata[`I2CC_TS_SDA] = sda_s;
        next_prdata[`I2CC_TS_SCL] = scl_s;
      end
      `I2CC_FILT_HIT: next_prdata[1:0] = filter_hit;
      `I2CC_FILT_DIR: next_prdata[0] = filter_dir;
      `I2CC_IRQ_FLAG: next_prdata = irq_flags;
      `I2CC_IRQ_CLR: next_prdata = `I2CC_ZERO;
      `I2CC_IRQ_EN: next_prdata = irq_enable;
      `I2CC_SAMPLE_DIV: next_prdata = line_sample_divider;
      `I2CC_TIMEOUT: next_prdata = timeout_count;
      `I2CC_SETUP: next_prdata = data_setup_count;
      `I2CC_LOW: next_prdata = scl_low_count;
      `I2CC_HIGH: next_prdata = scl_high_count;
      `I2CC_FREE: next_prdata = bus_free_count;
      `I2CC_OVERRIDE: next_prdata = override;
      `I2CC_TADDR0: next_prdata = target_address_setting_0;
      `I2CC_TADDR1: next_prdata = target_address_setting_1;
      default: addr_ok = 1'b0;
    endcase
  end

  // read data captured in the setup cycle, valid in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `I2CC_ZERO;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  // configuration writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_sample_divider <= `I2CC_TIME_RST;
      timeout_count <= `I2CC_TIME_RST;
      data_setup_count <= `I2CC_TIME_RST;
      scl_low_count <= `I2CC_TIME_RST;
      scl_high_count <= `I2CC_TIME_RST;
      bus_free_count <= `I2CC_TIME_RST;
      override <= `I2CC_OVR_RST;
      target_address_setting_0 <= `I2CC_ZERO;
      target_address_setting_1 <= `I2CC_ZERO;
      irq_enable <= `I2CC_ZERO;
    end else if (wr_en) begin
      case (paddr)
        `I2CC_SAMPLE_DIV: line_sample_divider <= pwdata;
        `I2CC_TIMEOUT: timeout_count <= pwdata;
        `I2CC_SETUP: data_setup_count <= pwdata;
        `I2CC_LOW: scl_low_count <= pwdata;
        `I2CC_HIGH: scl_high_count <= pwdata;
        `I2CC_FREE: bus_free_count <= pwdata;
        `I2CC_OVERRIDE: override <= pwdata;
        `I2CC_TADDR0: target_address_setting_0 <= pwdata;
        `I2CC_TADDR1: target_address_setting_1 <= pwdata;
        `I2CC_IRQ_EN: irq_enable <= pwdata & `I2CC_IRQ_MASK;
        default: ;
      endcase
    end
  end

  // event set and write-one clear vectors, kept out of the clocked process
  always @* begin
    set_vec = `I2CC_ZERO;
    set_vec[`I2CC_IRQ_START] = start_det & ~in_frame;
    set_vec[`I2CC_IRQ_RESTART] = start_det & in_frame;
    set_vec[`I2CC_IRQ_END] = stop_det;
    set_vec[`I2CC_IRQ_DROP] = drop_evt;
    set_vec[`I2CC_IRQ_GEN_EXIT] = gen_exit;
    set_vec[`I2CC_IRQ_GEN_ENTER] = gen_enter;
    set_vec[`I2CC_IRQ_FILTER] = addr_done & (hit0 | hit1);
    clr_vec = (wr_en && paddr == `I2CC_IRQ_CLR) ? pwdata : `I2CC_ZERO;
  end

  // sticky event flags, a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flags <= `I2CC_ZERO;
    end else begin
      irq_flags <= ((irq_flags & ~clr_vec) | set_vec) & `I2CC_IRQ_MASK;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame <= 1'b0;
      idle_cnt <= `I2CC_ZERO;
    end else begin
      if (start_det) begin
        in_frame <= 1'b1;
      end else if (stop_det | drop_evt) begin
        in_frame <= 1'b0;
      end
      // silence counted only inside a frame
      if (activity | ~in_frame | timeout_hit) begin
        idle_cnt <= `I2CC_ZERO;
      end else begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_phase <= 1'b0;
      bit_cnt <= 3'h0;
      addr_shift <= 8'h00;
      filter_hit <= 2'h0;
      filter_dir <= 1'b0;
    end else if (start_det) begin
      // each start or restart opens a new address byte
      addr_phase <= 1'b1;
      bit_cnt <= 3'h0;
      filter_hit <= 2'h0;
    end else if (stop_det | drop_evt) begin
      addr_phase <= 1'b0;
    end else if (addr_phase & scl_rise) begin
      addr_shift <= addr_byte;
      bit_cnt <= bit_cnt + 1'b1;
      if (addr_done) begin
        addr_phase <= 1'b0;
        filter_hit <= {hit1, hit0};
        filter_dir <= addr_byte[0];
      end
    end
  end

  // bus-free timer restarts on every stop or drop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_cnt <= `I2CC_ZERO;
    end else if (stop_det | drop_evt) begin
      free_cnt <= `I2CC_ZERO;
    end else if (free_cnt != 32'hFFFF_FFFF) begin
      free_cnt <= free_cnt + 1'b1;
    end
  end

  // controller sequencer; outside idle a drop request outranks everything
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      phase_cnt <= `I2CC_ZERO;
      rec_cnt <= 4'h0;
      drv_sda <= 1'b0;
      drv_scl <= 1'b0;
      req_start <= 1'b0;
      req_stop <= 1'b0;
      req_drop <= 1'b0;
      req_rec <= 1'b0;
      err_start <= 1'b0;
      err_stop <= 1'b0;
      err_rec <= 1'b0;
    end else begin
      phase_cnt <= phase_cnt + 1'b1;
      // software requests and error clears
      if (wr_en && paddr == `I2CC_CMD) begin
        req_start <= req_start | pwdata[`I2CC_CS_START];
        req_stop <= req_stop | pwdata[`I2CC_CS_STOP];
        req_drop <= req_drop | pwdata[`I2CC_CS_DROP];
        req_rec <= req_rec | pwdata[`I2CC_CS_RECOVER];
      end
      if (wr_en && paddr == `I2CC_CTRL_STAT) begin
        err_start <= err_start & ~pwdata[`I2CC_CS_ERR_START];
        err_stop <= err_stop & ~pwdata[`I2CC_CS_ERR_STOP];
        err_rec <= err_rec & ~pwdata[`I2CC_CS_ERR_REC];
      end
      if (req_drop & (state == ST_IDLE)) begin
        // nothing to drop, request simply retires
        req_drop <= 1'b0;
      end
      if (ctrl_drop) begin
        // note which sequence was cut short
        if (state == ST_WFREE || state == ST_SSDA || state == ST_SSCL) begin
          err_start <= 1'b1;
        end
        if (state == ST_PSETUP || state == ST_PSCL || state == ST_PSDA) begin
          err_stop <= 1'b1;
        end
        if (state == ST_RLOW || state == ST_RHIGH) begin
          err_rec <= 1'b1;
        end
        // release both lines at once
        state <= ST_IDLE;
        drv_sda <= 1'b0;
        drv_scl <= 1'b0;
        req_start <= 1'b0;
        req_stop <= 1'b0;
        req_drop <= 1'b0;
        req_rec <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            phase_cnt <= `I2CC_ZERO;
            if (req_rec) begin
              rec_cnt <= 4'h0;
              drv_scl <= 1'b1;
              state <= ST_RLOW;
            end else if (req_start) begin
              state <= ST_WFREE;
            end else if (req_stop) begin
              // stop with nothing owned retires at once
              req_stop <= 1'b0;
            end
          end
          ST_WFREE: begin
            phase_cnt <= `I2CC_ZERO;
            if (bus_free) begin
              drv_sda <= 1'b1;
              state <= ST_SSDA;
            end
          end
          ST_SSDA: begin
            // start hold counted with scl seen high
            if (~scl_s) begin
              phase_cnt <= `I2CC_ZERO;
            end else if (high_done) begin
              phase_cnt <= `I2CC_ZERO;
              drv_scl <= 1'b1;
              state <= ST_SSCL;
            end
          end
          ST_SSCL: begin
            if (low_done) begin
              req_start <= 1'b0;
              state <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            phase_cnt <= `I2CC_ZERO;
            if (req_rec) begin
              rec_cnt <= 4'h0;
              drv_sda <= 1'b0;
              state <= ST_RLOW;
            end else if (req_stop) begin
              // stop bit placed on sda under low scl
              drv_sda <= 1'b1;
              state <= ST_PSETUP;
            end
          end
          ST_PSETUP: begin
            // stretch scl low for the larger of setup+1 and low+1 after sda change
            if (setup_done & low_done) begin
              phase_cnt <= `I2CC_ZERO;
              drv_scl <= 1'b0;
              state <= ST_PSCL;
            end
          end
          ST_PSCL: begin
            // scl high for high+1 before sda rises
            if (~scl_s) begin
              phase_cnt <= `I2CC_ZERO;
            end else if (high_done) begin
              drv_sda <= 1'b0;
              state <= ST_PSDA;
            end
          end
          ST_PSDA: begin
            req_stop <= 1'b0;
            req_rec <= 1'b0;
            state <= ST_IDLE;
          end
          ST_RLOW: begin
            if (low_done) begin
              phase_cnt <= `I2CC_ZERO;
              drv_scl <= 1'b0;
              state <= ST_RHIGH;
            end
          end
          ST_RHIGH: begin
            // recover clock high phase, stretch aware
            if (~scl_s) begin
              phase_cnt <= `I2CC_ZERO;
            end else if (high_done) begin
              phase_cnt <= `I2CC_ZERO;
              drv_scl <= 1'b1;
              rec_cnt <= rec_cnt + 1'b1;
              if (rec_cnt + 4'h1 == `I2CC_REC_PULSES) begin
                // finish with a stop to leave the bus clean
                drv_sda <= 1'b1;
                state <= ST_PSETUP;
              end else begin
                state <= ST_RLOW;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // i2cc_top

// ---- testbench/i2cc_monitor.sv ----
// port checks for the i2c status and timing block
`timescale 1ns/1ps
`include "i2cc_defs.vh"
module i2cc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // a register write taking effect this edge
  wire logic wr = psel && penable && pwrite;
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("sda data pin not low");
  a_scl_open_drain: assert property (scl_o == 1'b0)
    else $error("scl data pin not low");
  a_irq_fall_cause: assert property ($fell(irq) |->
    $past(wr && (paddr == `I2CC_IRQ_CLR || paddr == `I2CC_IRQ_EN)))
    else $error("irq fell without clear or mask write");
  a_irq_mask_off: assert property (wr && paddr == `I2CC_IRQ_EN && pwdata == 32'h0 |=> !irq)
    else $error("irq high with all enables off");
  a_ovr_sda_pull: assert property (wr && paddr == `I2CC_OVERRIDE && !pwdata[1] |=> sda_oe)
    else $error("sda override did not pull");
  a_ovr_scl_pull: assert property (wr && paddr == `I2CC_OVERRIDE && !pwdata[2] |=> scl_oe)
    else $error("scl override did not pull");
  // setup, low, high and free counts in the bench are never below 2, so each phase spans at least 3 clocks
  a_start_high: assert property ($rose(sda_oe) && !scl_oe |-> !scl_oe[*3])
    else $error("scl high phase too short");
  a_low_phase: assert property ($rose(scl_oe) && sda_oe |-> scl_oe[*3])
    else $error("scl low phase too short");
  c_irq: cover property ($rose(irq));
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_low: cover property ($rose(scl_oe) && sda_oe);
endmodule // i2cc_monitor

// ---- testbench/i2cc_bus_peer.sv ----
// open-drain peer on the i2c wires: start, address byte, stop
`timescale 1ns/1ps
module i2cc_bus_peer (
  input wire logic pclk,
  input wire logic sda_oe,
  input wire logic scl_oe,
  output wire logic sda_i,
  output wire logic scl_i
);
  logic sda_low = 1'b0; // peer pulls sda
  logic scl_low = 1'b0; // peer pulls scl
  // wired-and with pull-ups, so a released line reads high
  assign sda_i = !(sda_oe || sda_low);
  assign scl_i = !(scl_oe || scl_low);
  // set both pulls, then hold a third of a bit
  task automatic step(input logic s, input logic c);
    sda_low <= s;
    scl_low <= c;
    repeat (20) @(posedge pclk);
  endtask
  // start or repeated start, scl left low
  task automatic start();
    step(1'b0, scl_low);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      step(!b[i], 1'b1);
      step(!b[i], 1'b0);
      step(!b[i], 1'b1);
    end
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
  endtask
  // sda rises while scl is high
  task automatic stop();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule // i2cc_bus_peer

// ---- testbench/test_i2c_controller_status_timing.sv ----
// self-checking bench for the i2c status, timing and filter block
`timescale 1ns/1ps
`include "i2cc_defs.vh"
module test_i2c_controller_status_timing;
  logic pclk = 1'b0; // 40 MHz
  logic presetn = 1'b0; // async, low active
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [7:0] paddr = 8'h00; // byte address
  logic [31:0] pwdata = 32'h0000_0000; // write data
  wire [31:0] prdata; // read data
  wire pready, pslverr, sda_i, sda_o, sda_oe, scl_i, scl_o, scl_oe, irq; // outputs and wires
  int fails = 0; // mismatches
  int samples_checked = 0; // comparisons
  int cycles = 0; // hang guard
  logic [31:0] q, t0, t1; // read data and target settings
  logic err; // slave error of last transfer
  logic [6:0] ad; // random address
  logic [1:0] hit; // expected filter hits
  always #12.5 pclk = ~pclk;
  i2cc_top i2cc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe(scl_oe), .irq(irq));
  i2cc_bus_peer i2cc_bus_peer_i (.pclk(pclk), .sda_oe(sda_oe), .scl_oe(scl_oe),
    .sda_i(sda_i), .scl_i(scl_i));
  // a run needs about 5000 clocks
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, held until pready is seen at an access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready seen high ends this wait, the bench timeout only if it never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // read and compare only the bits under the mask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, q & m, e);
  endtask
  function automatic logic [1:0] exp_hit(input logic [31:0] s0, input logic [31:0] s1,
      input logic [6:0] a);
    return {s1[31] && s1[6:0] == a, s0[31] && s0[6:0] == a};
  endfunction
  initial begin
    void'($urandom(80452));
    idle(20);
    presetn <= 1'b1;
    for (int a = 8'h30; a <= 8'h44; a += 4)
      rd(a[7:0], 32'hFFFF_FFFF, `I2CC_TIME_RST, "count reset");
    rd(`I2CC_OVERRIDE, 32'hFFFF_FFFF, `I2CC_OVR_RST, "override reset");
    // unmapped place refuses with zero data
    rd(8'h14, 32'hFFFF_FFFF, `I2CC_ZERO, "unmapped read");
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    wr(`I2CC_OVERRIDE, `I2CC_ZERO);
    idle(20);
    rd(`I2CC_TGT_STAT, 32'h0000_0006, `I2CC_ZERO, "override low");
    wr(`I2CC_OVERRIDE, `I2CC_OVR_RST);
    idle(20);
    rd(`I2CC_TGT_STAT, 32'h0000_0006, 32'h0000_0006, "override free");
    // a line change waits for the next divided sample
    wr(`I2CC_SAMPLE_DIV, `I2CC_ZERO);
    wr(`I2CC_SAMPLE_DIV, 32'h0000_0064);
    i2cc_bus_peer_i.step(1'b1, 1'b0);
    rd(`I2CC_TGT_STAT, 32'h0000_0006, 32'h0000_0006, "sample held");
    idle(100);
    rd(`I2CC_TGT_STAT, 32'h0000_0006, 32'h0000_0004, "sample taken");
    wr(`I2CC_SAMPLE_DIV, `I2CC_TIME_RST);
    // live levels follow random peer pulls
    for (int i = 0; i < 4; i++) begin
      t0 = $urandom;
      i2cc_bus_peer_i.step(t0[0], t0[1]);
      rd(`I2CC_TGT_STAT, 32'h0000_0006, {29'h0, ~t0[1], ~t0[0], 1'b0}, "levels");
    end
    i2cc_bus_peer_i.step(1'b0, 1'b0);
    wr(`I2CC_TIMEOUT, 32'h0000_0FFF);
    // address matches setting 0 for k 0, setting 1 for k 1, both for k 2, a disabled setting 0 for k 3
    for (int k = 0; k < 4; k++) begin
      ad = $urandom;
      t0 = $urandom;
      t1 = $urandom;
      t0[6:0] = (k != 1) ? ad : t0[6:0];
      t0[31] = (k != 3);
      t1[6:0] = (k == 1 || k == 2) ? ad : t1[6:0];
      wr(`I2CC_TADDR0, t0);
      wr(`I2CC_TADDR1, t1);
      wr(`I2CC_IRQ_CLR, 32'hFFFF_FFFF);
      hit = exp_hit(t0, t1, ad);
      i2cc_bus_peer_i.start();
      rd(`I2CC_TGT_STAT, 32'h0000_0001, 32'h0000_0001, "in frame");
      i2cc_bus_peer_i.send_byte({ad, k[0]});
      i2cc_bus_peer_i.stop();
      idle(20);
      rd(`I2CC_FILT_HIT, 32'h0000_0003, {30'h0, hit}, "filter hit");
      rd(`I2CC_FILT_DIR, 32'h0000_0001, {31'h0, k[0]}, "direction");
      rd(`I2CC_IRQ_FLAG, 32'h0002_0050, {14'h0, |hit, 17'h00050}, "frame flags");
      rd(`I2CC_TGT_STAT, 32'h0000_0001, `I2CC_ZERO, "frame ended");
    end
    // restart, then a stall longer than the timeout
    wr(`I2CC_TIMEOUT, 32'h0000_00C8);
    wr(`I2CC_IRQ_CLR, 32'hFFFF_FFFF);
    i2cc_bus_peer_i.start();
    i2cc_bus_peer_i.send_byte({ad, 1'b0});
    i2cc_bus_peer_i.start();
    rd(`I2CC_TGT_STAT, 32'h0000_0001, 32'h0000_0001, "before timeout");
    idle(300);
    rd(`I2CC_TGT_STAT, 32'h0000_0001, `I2CC_ZERO, "after timeout");
    rd(`I2CC_IRQ_FLAG, 32'h0000_00A0, 32'h0000_00A0, "restart drop");
    wr(`I2CC_IRQ_CLR, `I2CC_ZERO);
    rd(`I2CC_IRQ_FLAG, 32'h0000_0080, 32'h0000_0080, "zero clear");
    wr(`I2CC_IRQ_EN, 32'h0000_0080);
    idle(1);
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    wr(`I2CC_IRQ_EN, `I2CC_ZERO);
    idle(1);
    chk("irq masked", {31'h0, irq}, `I2CC_ZERO);
    wr(`I2CC_IRQ_EN, 32'h0000_0080);
    wr(`I2CC_IRQ_CLR, 32'h0000_0080);
    idle(1);
    chk("irq cleared", {31'h0, irq}, `I2CC_ZERO);
    i2cc_bus_peer_i.stop();
    wr(`I2CC_TIMEOUT, 32'h0000_0FFF);
    // controller: start queued behind a peer frame
    for (int a = 8'h38; a <= 8'h44; a += 4)
      wr(a[7:0], 32'h0000_0002);
    wr(`I2CC_IRQ_CLR, 32'hFFFF_FFFF);
    i2cc_bus_peer_i.start();
    wr(`I2CC_CMD, 32'h0000_0010);
    rd(`I2CC_CTRL_STAT, 32'h0000_0010, 32'h0000_0010, "start pending");
    i2cc_bus_peer_i.stop();
    for (int n = 0; n < 400 && scl_oe !== 1'b1; n++)
      idle(1);
    chk("gen start", {31'h0, scl_oe}, 32'h0000_0001);
    idle(10);
    rd(`I2CC_CTRL_STAT, 32'h0000_00F1, 32'h0000_0001, "holding");
    rd(`I2CC_IRQ_FLAG, 32'h0001_0000, 32'h0001_0000, "gen enter");
    wr(`I2CC_CMD, 32'h0000_0020);
    idle(100);
    rd(`I2CC_CTRL_STAT, 32'h0000_00F1, `I2CC_ZERO, "stopped");
    rd(`I2CC_IRQ_FLAG, 32'h0000_8000, 32'h0000_8000, "gen exit");
    chk("lines free", {30'h0, sda_i, scl_i}, 32'h0000_0003);
    wr(`I2CC_CMD, 32'h0000_0080);
    idle(300);
    rd(`I2CC_CTRL_STAT, 32'h0000_00F1, `I2CC_ZERO, "recovered");
    // drop while start runs, then one-clear
    wr(`I2CC_CMD, 32'h0000_0010);
    wr(`I2CC_CMD, 32'h0000_0040);
    idle(20);
    rd(`I2CC_CTRL_STAT, 32'h0000_02F1, 32'h0000_0200, "start dropped");
    wr(`I2CC_CTRL_STAT, 32'h0000_0200);
    rd(`I2CC_CTRL_STAT, 32'h0000_0200, `I2CC_ZERO, "drop cleared");
    give_verdict();
  end
endmodule // test_i2c_controller_status_timing
bind i2cc_top i2cc_monitor i2cc_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sda_o(sda_o),
  .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe), .irq(irq));
